// file: src/rbs_boot_ctrl.sv
// What this block does
// - After reset, fetch stack pointer from word 0x0, then PC from 0x4.
// - After both fetches, start the core at the fetched PC.
// - In reset, non-debug digital pins are undriven with pulls off.
// - Analog-capable pins default to their analog function in reset.
// - Non-debug digital pins stay disabled until software enables them.
// - After reset interrupts are off and peripheral clock gates are off.
// - After reset the clock generator selects the FLL internal mode.
// - Watchdog runs after reset; software services or disables it.
// - Core, system and flash clocks are on after reset.
// - Flash cache and prefetch buffers are on after reset.
// - Writing 0x00 to watchdog control clears timeout, disabling it.
// - Mux value 0x1 is GPIO; interrupt config 0x9 is rising edge.
// - Each qualifying pin edge raises exactly one interrupt.
`timescale 1ns/1ns
`default_nettype none
module rbs_boot_ctrl
    import rbs_pkg::*;
#(
    parameter int WDOG_UNIT_CYC = 8192  // Watchdog cycles per timeout step
)
(
    input  wire logic        clk_i,          // System clock, 100 MHz
    input  wire logic        resetn_i,       // Async reset, active low
    output logic             vec_req_o,      // Vector fetch request
    output logic [31:0]      vec_addr_o,     // Vector fetch byte address
    input  wire logic        vec_ack_i,      // Fetch data valid
    input  wire logic [31:0] vec_rdata_i,    // Fetch data
    output logic             core_run_o,     // Core released to execute
    output logic [31:0]      core_sp_o,      // Initial stack pointer
    output logic [31:0]      core_pc_o,      // Initial program counter
    input  wire logic        vtab_ram_i,     // Request table in SRAM
    output logic [31:0]      vtab_base_o,    // Active vector table base
    input  wire logic        port_clk_en_i,  // Software port clock enable
    output logic             port_clk_o,     // Port clock gate
    input  wire logic        periph_clk_i,   // Software peripheral clocks
    output logic             periph_clk_o,   // Peripheral clock gate
    output logic             core_clk_o,     // Core clock enable
    output logic             sys_clk_o,      // System clock enable
    output logic             flash_clk_o,    // Flash clock enable
    output logic             cache_en_o,     // Flash cache enable
    output logic             prefetch_en_o,  // Flash prefetch enable
    output rbs_clk_mode_t    clk_mode_o,     // Clock generator mode
    input  wire logic        irq_enable_i,   // Software interrupt enable
    output logic             irq_en_o,       // Interrupts enabled
    input  wire logic        pinctl_wr_i,    // Pin control write strobe
    input  wire logic [2:0]  pinctl_mux_i,   // Pin control mux value
    input  wire logic [3:0]  pinctl_icfg_i,  // Pin control irq config
    input  wire logic        pin_en_wr_i,    // Digital enable write
    input  wire logic [7:0]  pin_en_i,       // Digital enables per pin
    input  wire logic [7:0]  pin_level_i,    // Pin input levels
    output logic [7:0]       pin_dig_en_o,   // Digital buffer enable
    output logic [7:0]       pin_pull_en_o,  // Pull resistor enable
    output logic [7:0]       pin_analog_o,   // Analog function select
    output logic             pin_irq_o,      // Button edge interrupt
    input  wire logic        wdog_wr_i,      // Watchdog control write
    input  wire logic [7:0]  wdog_wdata_i,   // Watchdog control data
    input  wire logic        wdog_service_i, // Watchdog service strobe
    output logic [7:0]       wdog_ctrl_o,    // Watchdog control readback
    output logic             wdog_active_o,  // Watchdog counting
    output logic             wdog_reset_o    // Watchdog timeout pulse
);

    typedef struct packed {
        rbs_state_t                 st;
        logic [31:0]                addr;
        logic                       req;
        logic [31:0]                sp;
        logic [31:0]                pc;
        logic                       run;
        logic                       vram;
        logic                       port_clk;
        logic                       periph_clk;
        logic                       irq_en;
        logic [2:0]                 mux;
        logic [3:0]                 icfg;
        logic [7:0]                 dig_en;
        logic [7:0]                 wctl;
        logic [RBS_WDOG_CNT_W-1:0]  wcnt;
        logic                       wbite;
        logic [31:0]                vbase;
        logic [7:0]                 ana;
        logic                       wact;
    } rbs_state_s_t;

    rbs_state_s_t s_q;
    rbs_state_s_t s_d;
    logic [1:0]   rst_sync_q;
    logic         rst_n;
    logic         irq_pulse;
    rbs_pin_if    pin ();

    // Timeout length in cycles for a given field value
    function automatic logic [RBS_WDOG_CNT_W-1:0] wdog_limit(
        input logic [RBS_WDOG_T_W-1:0] t
    );
        logic [RBS_WDOG_CNT_W-1:0] lim;
        lim = RBS_WDOG_CNT_W'(WDOG_UNIT_CYC) * RBS_WDOG_CNT_W'(t);
        return lim;
    endfunction

    // Table base: flash during boot, SRAM only once running
    function automatic logic [31:0] vtab_base(input logic ram);
        return ram ? RBS_SRAM_BASE : RBS_FLASH_BASE;
    endfunction

    // Reset assert is immediate, release passes two flops
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rst_sync_q <= 2'b00;
        end
        else
        begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Next-state logic for the whole block
    always_comb
    begin
        logic [RBS_WDOG_T_W-1:0] tfield;
        tfield  = s_q.wctl[RBS_WDOG_T_LSB +: RBS_WDOG_T_W];
        s_d     = s_q;
        s_d.req = 1'b0;

        // Vector fetch sequencer
        unique case (s_q.st)
            RBS_ST_HOLD:
            begin
                s_d.st = RBS_ST_REQ_SP;
            end
            RBS_ST_REQ_SP:
            begin
                s_d.req  = 1'b1;
                s_d.addr = RBS_FLASH_BASE + RBS_VEC_SP_OFS;
                s_d.st   = RBS_ST_WAIT_SP;
            end
            RBS_ST_WAIT_SP:
            begin
                s_d.req = !vec_ack_i;
                if (vec_ack_i)
                begin
                    s_d.sp = vec_rdata_i;
                    s_d.st = RBS_ST_REQ_PC;
                end
            end
            RBS_ST_REQ_PC:
            begin
                s_d.req  = 1'b1;
                s_d.addr = RBS_FLASH_BASE + RBS_VEC_PC_OFS;
                s_d.st   = RBS_ST_WAIT_PC;
            end
            RBS_ST_WAIT_PC:
            begin
                s_d.req = !vec_ack_i;
                if (vec_ack_i)
                begin
                    s_d.pc  = vec_rdata_i;
                    s_d.run = 1'b1;
                    s_d.st  = RBS_ST_RUN;
                end
            end
            RBS_ST_RUN:
            begin
                s_d.vram = vtab_ram_i;
            end
        endcase

        // Software settings only take effect once the core runs
        if (s_q.run)
        begin
            s_d.port_clk   = port_clk_en_i;
            s_d.periph_clk = periph_clk_i;
            s_d.irq_en     = irq_enable_i;
            if (pin_en_wr_i)
            begin
                s_d.dig_en = pin_en_i | RBS_SWD_MASK;
            end
            // Mux changes are dropped while the port clock is gated
            if (pinctl_wr_i && s_q.port_clk)
            begin
                s_d.mux  = pinctl_mux_i;
                s_d.icfg = pinctl_icfg_i;
            end
        end
        if (s_q.mux == RBS_MUX_GPIO)
        begin
            s_d.dig_en[RBS_BTN_PIN] = 1'b1;
        end

        // Watchdog: a zero timeout field stops it, a service restarts it
        s_d.wbite = 1'b0;
        if (tfield == '0)
        begin
            s_d.wcnt = '0;
        end
        else if (wdog_service_i)
        begin
            s_d.wcnt = '0;
        end
        else if (s_q.wcnt >= wdog_limit(tfield) - 1'b1)
        begin
            s_d.wcnt  = '0;
            s_d.wbite = 1'b1;
        end
        else
        begin
            s_d.wcnt = s_q.wcnt + 1'b1;
        end
        // No software before run, so early writes are dropped: dog stays up
        if (wdog_wr_i && s_q.run)
        begin
            s_d.wctl = wdog_wdata_i;
            s_d.wcnt = '0;
        end

        // Derived outputs sit in flops so no output is combinational
        s_d.vbase = vtab_base(s_d.vram);
        s_d.ana   = RBS_ANALOG_MASK & ~s_d.dig_en;
        s_d.wact  = |s_d.wctl[RBS_WDOG_T_LSB +: RBS_WDOG_T_W];
    end

    // Reset values set the documented power-on device state
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q            <= '0;
            s_q.st         <= RBS_ST_HOLD;
            s_q.irq_en     <= 1'b0;
            s_q.periph_clk <= 1'b0;
            s_q.mux        <= RBS_MUX_OFF;
            s_q.icfg       <= RBS_ICFG_OFF;
            s_q.dig_en     <= RBS_SWD_MASK;
            s_q.wctl       <= RBS_WDOG_RST;
            s_q.vbase      <= RBS_FLASH_BASE;
            s_q.ana        <= RBS_ANALOG_MASK & ~RBS_SWD_MASK;
            s_q.wact       <= |RBS_WDOG_RST[RBS_WDOG_T_LSB +: RBS_WDOG_T_W];
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Button pin edge detector
    assign pin.mux    = s_q.mux;
    assign pin.icfg   = s_q.icfg;
    assign pin.irq_en = s_q.irq_en;
    assign irq_pulse  = pin.irq_pulse;

    rbs_pin_edge u_edge (
        .clk_i   (clk_i),
        .rst_ni  (rst_n),
        .level_i (pin_level_i[RBS_BTN_PIN]),
        .pin     (pin.edge_det)
    );

    // Outputs, all straight from state flops except the fixed pull enable RBS_SWD_MASK
    assign vec_req_o     = s_q.req;
    assign vec_addr_o    = s_q.addr;
    assign core_run_o    = s_q.run;
    assign core_sp_o     = s_q.sp;
    assign core_pc_o     = s_q.pc;
    assign vtab_base_o   = s_q.vbase;
    assign port_clk_o    = s_q.port_clk;
    assign periph_clk_o  = s_q.periph_clk;
    assign irq_en_o      = s_q.irq_en;
    assign pin_dig_en_o  = s_q.dig_en;
    assign pin_pull_en_o = RBS_SWD_MASK;
    assign pin_analog_o  = s_q.ana;
    assign pin_irq_o     = irq_pulse;
    assign wdog_ctrl_o   = s_q.wctl;
    assign wdog_active_o = s_q.wact;
    assign wdog_reset_o  = s_q.wbite;
    // Boot clocks and flash features are fixed on
    assign core_clk_o    = 1'b1;
    assign sys_clk_o     = 1'b1;
    assign flash_clk_o   = 1'b1;
    assign cache_en_o    = 1'b1;
    assign prefetch_en_o = 1'b1;
    assign clk_mode_o    = RBS_CLK_FLL_INT;

endmodule // rbs_boot_ctrl
`default_nettype wire

// file: src/rbs_pin_edge.sv
`timescale 1ns/1ns
`default_nettype none
module rbs_pin_edge
    import rbs_pkg::*;
(
    input  wire logic    clk_i,    // System clock
    input  wire logic    rst_ni,   // Synchronised reset, active low
    input  wire logic    level_i,  // Pin level, synchronous to clk_i
    rbs_pin_if.edge_det  pin       // Settings and interrupt pulse
);

    typedef struct packed {
        logic last;
        logic pulse;
    } rbs_edge_t;

    rbs_edge_t s_q;
    rbs_edge_t s_d;

    // One pulse per low-to-high transition, only as GPIO with rising mode and irq_en set
    always_comb
    begin
        s_d       = s_q;
        s_d.last  = level_i;
        s_d.pulse = level_i && !s_q.last
                    && (pin.mux == RBS_MUX_GPIO)
                    && (pin.icfg == RBS_ICFG_RISE)
                    && pin.irq_en;
    end

    // Last starts high so a pin already high at release gives no pulse
    always_ff @(posedge clk_i or negedge rst_ni)
    begin
        if (!rst_ni)
        begin
            s_q <= '{last: 1'b1, pulse: 1'b0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign pin.irq_pulse = s_q.pulse;

endmodule // rbs_pin_edge
`default_nettype wire

// file: src/rbs_pin_if.sv
`timescale 1ns/1ns
`default_nettype none
// Pin control settings for the button pin and its edge interrupt
interface rbs_pin_if;
    logic [2:0] mux;       // Pin function select
    logic [3:0] icfg;      // Pin interrupt configuration
    logic       irq_en;    // Global interrupt enable
    logic       irq_pulse; // One pulse per qualifying edge

    modport ctl  (output mux, output icfg, output irq_en, input irq_pulse);
    modport edge_det (input mux, input icfg, input irq_en, output irq_pulse);
endinterface
`default_nettype wire

// file: src/rbs_pkg.sv
package rbs_pkg;

    // Vector table layout (byte offsets from the table base)
    localparam logic [31:0] RBS_FLASH_BASE  = 32'h0000_0000;
    localparam logic [31:0] RBS_VEC_SP_OFS  = 32'h0000_0000;
    localparam logic [31:0] RBS_VEC_PC_OFS  = 32'h0000_0004;
    localparam logic [31:0] RBS_SRAM_BASE   = 32'h2000_0000;

    // Pin bank layout
    localparam int          RBS_NPINS       = 8;
    localparam logic [7:0]  RBS_SWD_MASK    = 8'h03;
    localparam logic [7:0]  RBS_ANALOG_MASK = 8'hC0;
    localparam int          RBS_BTN_PIN     = 4;

    // Pin control fields
    localparam logic [2:0]  RBS_MUX_OFF     = 3'h0;
    localparam logic [2:0]  RBS_MUX_GPIO    = 3'h1;
    localparam logic [3:0]  RBS_ICFG_OFF    = 4'h0;
    localparam logic [3:0]  RBS_ICFG_RISE   = 4'h9;

    // Watchdog control register and timeout field
    localparam logic [7:0]  RBS_WDOG_RST    = 8'h0C;
    localparam logic [7:0]  RBS_WDOG_OFF    = 8'h00;
    localparam int          RBS_WDOG_T_LSB  = 2;
    localparam int          RBS_WDOG_T_W    = 2;
    localparam int          RBS_WDOG_CNT_W  = 20;

    // Clock generator modes
    typedef enum logic [1:0] {
        RBS_CLK_FLL_INT,
        RBS_CLK_FLL_EXT,
        RBS_CLK_BYP_INT,
        RBS_CLK_BYP_EXT
    } rbs_clk_mode_t;

    // Boot sequencer states
    typedef enum logic [2:0] {
        RBS_ST_HOLD,
        RBS_ST_REQ_SP,
        RBS_ST_WAIT_SP,
        RBS_ST_REQ_PC,
        RBS_ST_WAIT_PC,
        RBS_ST_RUN
    } rbs_state_t;

endpackage

// file: verification/rbs_boot_props.sv
`timescale 1ns/1ns
`default_nettype none
module rbs_boot_props
    import rbs_pkg::*;
(
    input wire logic          clk_i,         // Clock
    input wire logic          resetn_i,      // Reset, low
    input wire logic          vec_req_o,     // Fetch request
    input wire logic [31:0]   vec_addr_o,    // Fetch address
    input wire logic          vec_ack_i,     // Fetch ack
    input wire logic [31:0]   vec_rdata_i,   // Fetch data
    input wire logic          core_run_o,    // Core running
    input wire logic [31:0]   core_sp_o,     // Stack pointer
    input wire logic [31:0]   core_pc_o,     // Entry address
    input wire rbs_clk_mode_t clk_mode_o,    // Clock mode
    input wire logic [7:0]    pin_level_i,   // Pin levels
    input wire logic [7:0]    pin_dig_en_o,  // Digital enables
    input wire logic          pin_irq_o,     // Button irq
    input wire logic          wdog_wr_i,     // Watchdog write
    input wire logic [7:0]    wdog_wdata_i,  // Watchdog data
    input wire logic [7:0]    wdog_ctrl_o,   // Watchdog control
    input wire logic          wdog_active_o  // Watchdog counting
);
    // Single domain; checks pause while reset is low
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
    // Stack word taken, then a gap, then the entry word is asked for
    sequence s_sp_take;
        vec_req_o && vec_ack_i && vec_addr_o == RBS_VEC_SP_OFS;
    endsequence
    sequence s_pc_ask;
        !vec_req_o ##1 vec_req_o && vec_addr_o == RBS_VEC_PC_OFS;
    endsequence
    AST_SP_THEN_PC:
        assert property (s_sp_take |=> s_pc_ask)
        else $error("entry fetch not issued after stack fetch");
    AST_SP_LOAD:
        assert property (s_sp_take |=> core_sp_o == $past(vec_rdata_i))
        else $error("stack pointer not loaded from fetch");
    AST_PC_RUN:
        assert property (vec_req_o && vec_ack_i && vec_addr_o ==
            RBS_VEC_PC_OFS |=> core_run_o && core_pc_o == $past(vec_rdata_i))
        else $error("core not started at fetched entry");
    AST_RUN_CAUSE:
        assert property ($rose(core_run_o) |-> $past(vec_ack_i))
        else $error("core started without entry fetch");
    AST_DIG_OFF:
        assert property (!core_run_o |-> pin_dig_en_o == RBS_SWD_MASK)
        else $error("digital pins enabled before run");
    AST_CLK_MODE:
        assert property (clk_mode_o == RBS_CLK_FLL_INT)
        else $error("clock mode not internal engaged");
    AST_WDOG_RST:
        assert property (!core_run_o |-> wdog_ctrl_o == RBS_WDOG_RST
            && wdog_active_o)
        else $error("watchdog not running before boot ends");
    AST_WDOG_OFF:
        assert property (core_run_o && wdog_wr_i && wdog_wdata_i ==
            RBS_WDOG_OFF |=> wdog_ctrl_o == RBS_WDOG_OFF && !wdog_active_o)
        else $error("watchdog still active after clear");
    AST_EDGE:
        assert property (pin_irq_o |-> $past(pin_level_i[RBS_BTN_PIN]) &&
            !$past(pin_level_i[RBS_BTN_PIN], 2) ##1 !pin_irq_o)
        else $error("button irq without single rising edge");
endmodule // rbs_boot_props
`default_nettype wire

// file: verification/rbs_flash_model.sv
`timescale 1ns/1ns
`default_nettype none
// Flash holding the vector table; answers after dly_i wait cycles
module rbs_flash_model
    import rbs_pkg::*;
#(
    parameter logic [31:0] SP_W = 32'h2000_1F00, // Stack word
    parameter logic [31:0] PC_W = 32'h0000_04C1  // Entry word
)
(
    input  wire logic        clk_i,    // Clock
    input  wire logic        resetn_i, // Reset, low
    input  wire logic        req_i,    // Fetch request
    input  wire logic [31:0] addr_i,   // Fetch address
    input  wire logic [3:0]  dly_i,    // Wait cycles
    output logic             ack_o,    // Data valid
    output logic [31:0]      rdata_o   // Data
);
    logic [3:0] cnt_q;
    // Idle data flips every cycle so a stale word never looks valid
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ack_o   <= 1'b0;
            cnt_q   <= 4'h0;
            rdata_o <= 32'hA5A5_5A5A;
        end
        else if (!ack_o && req_i && cnt_q >= dly_i)
        begin
            ack_o   <= 1'b1;
            cnt_q   <= 4'h0;
            // Table read from flash base while booting
            rdata_o <= (addr_i == RBS_FLASH_BASE + RBS_VEC_PC_OFS) ? PC_W
                     : (addr_i == RBS_FLASH_BASE) ? SP_W : ~rdata_o;
        end
        else
        begin
            ack_o   <= 1'b0;
            cnt_q   <= (req_i && !ack_o) ? cnt_q + 4'h1 : 4'h0;
            rdata_o <= ~rdata_o;
        end
    end
endmodule // rbs_flash_model
`default_nettype wire

// file: verification/tb_rbs_boot_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module tb_rbs_boot_ctrl
    import rbs_pkg::*;
;
    localparam logic [31:0] SP_W = 32'h2000_1F00;
    localparam logic [31:0] PC_W = 32'h0000_04C1;
    logic clk_i = 1'b0;
    logic resetn_i, vec_req_o, vec_ack_i, core_run_o, vtab_ram_i, port_clk_o;
    logic port_clk_en_i, periph_clk_i, periph_clk_o, core_clk_o, sys_clk_o;
    logic flash_clk_o, cache_en_o, prefetch_en_o, irq_enable_i, irq_en_o;
    logic pinctl_wr_i, pin_en_wr_i, pin_irq_o, wdog_wr_i, wdog_service_i;
    logic wdog_active_o, wdog_reset_o;
    logic [31:0] vec_addr_o, vec_rdata_i, core_sp_o, core_pc_o, vtab_base_o;
    logic [2:0] pinctl_mux_i;
    logic [3:0] pinctl_icfg_i, dly;
    logic [7:0] pin_en_i, pin_level_i, pin_dig_en_o, pin_pull_en_o;
    logic [7:0] pin_analog_o, wdog_wdata_i, wdog_ctrl_o;
    rbs_clk_mode_t clk_mode_o;
    int miscompares = 0;
    int checks_done = 0;
    int n;
    // 100 MHz clock
    always #5 clk_i = ~clk_i;
    // Short watchdog step keeps timeouts within a few dozen cycles
    rbs_boot_ctrl #(.WDOG_UNIT_CYC(4)) rbs_boot_ctrl_inst (
        .clk_i(clk_i), .resetn_i(resetn_i), .vec_req_o(vec_req_o),
        .vec_addr_o(vec_addr_o), .vec_ack_i(vec_ack_i),
        .vec_rdata_i(vec_rdata_i), .core_run_o(core_run_o),
        .core_sp_o(core_sp_o), .core_pc_o(core_pc_o),
        .vtab_ram_i(vtab_ram_i), .vtab_base_o(vtab_base_o),
        .port_clk_en_i(port_clk_en_i), .port_clk_o(port_clk_o),
        .periph_clk_i(periph_clk_i), .periph_clk_o(periph_clk_o),
        .core_clk_o(core_clk_o), .sys_clk_o(sys_clk_o),
        .flash_clk_o(flash_clk_o), .cache_en_o(cache_en_o),
        .prefetch_en_o(prefetch_en_o), .clk_mode_o(clk_mode_o),
        .irq_enable_i(irq_enable_i), .irq_en_o(irq_en_o),
        .pinctl_wr_i(pinctl_wr_i), .pinctl_mux_i(pinctl_mux_i),
        .pinctl_icfg_i(pinctl_icfg_i),
        .pin_en_wr_i(pin_en_wr_i), .pin_en_i(pin_en_i),
        .pin_level_i(pin_level_i), .pin_dig_en_o(pin_dig_en_o),
        .pin_pull_en_o(pin_pull_en_o), .pin_analog_o(pin_analog_o),
        .pin_irq_o(pin_irq_o), .wdog_wr_i(wdog_wr_i),
        .wdog_wdata_i(wdog_wdata_i), .wdog_service_i(wdog_service_i),
        .wdog_ctrl_o(wdog_ctrl_o), .wdog_active_o(wdog_active_o),
        .wdog_reset_o(wdog_reset_o));
    rbs_flash_model #(.SP_W(SP_W), .PC_W(PC_W)) rbs_flash_model_inst (
        .clk_i(clk_i), .resetn_i(resetn_i), .req_i(vec_req_o),
        .addr_i(vec_addr_o), .dly_i(dly), .ack_o(vec_ack_i),
        .rdata_o(vec_rdata_i));
    // Shared helpers; inputs only move at the falling edge
    task automatic cyc(input int k);
        repeat (k) @(negedge clk_i);
    endtask
    task automatic chk(input string nm, input logic [31:0] ex, got);
        checks_done++;
        if (got !== ex)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Counts watchdog and button pulses over k cycles
    task automatic span(input int k);
        repeat (k)
        begin
            cyc(1);
            if (wdog_reset_o === 1'b1 || pin_irq_o === 1'b1)
                n++;
        end
    endtask
    task automatic pinctl(input logic [2:0] m, input logic [3:0] q);
        {pinctl_mux_i, pinctl_icfg_i, pinctl_wr_i} = {m, q, 1'b1};
        cyc(1);
        pinctl_wr_i = 1'b0;
        cyc(2);
    endtask
    task automatic edge_cnt(input int ex);
        pin_level_i[RBS_BTN_PIN] = 1'b0;
        cyc(2);
        n = 0;
        pin_level_i[RBS_BTN_PIN] = 1'b1;
        span(6);
        chk("edges", ex, n);
    endtask
    // Reset, check held state, try a refused write, wait for the core
    task automatic boot(input logic [3:0] d);
        {dly, resetn_i} = {d, 1'b0};
        cyc(8);
        chk("rst_pull", RBS_SWD_MASK, pin_pull_en_o);
        chk("rst_ana", RBS_ANALOG_MASK, pin_analog_o);
        resetn_i = 1'b1;
        cyc(4);
        wdog_wr_i = 1'b1;
        cyc(1);
        wdog_wr_i = 1'b0;
        for (n = 0; core_run_o !== 1'b1 && n < 200; n++)
            cyc(1);
        if (n == 200)
        begin
            miscompares++;
            $display("[ERR] core_run expected 1 seen %b", core_run_o);
            close_out();
        end
        chk("sp", SP_W, core_sp_o);
        chk("pc", PC_W, core_pc_o);
        chk("vtab", RBS_FLASH_BASE, vtab_base_o);
        chk("quiet", 32'h0000_0000, {irq_en_o, periph_clk_o, port_clk_o});
        chk("clk_on", 32'h0000_001F, {core_clk_o, sys_clk_o, flash_clk_o,
            cache_en_o, prefetch_en_o});
        chk("wdog", RBS_WDOG_RST, wdog_ctrl_o);
        $display("test boot done");
    endtask
    initial
    begin
        {vtab_ram_i, port_clk_en_i, periph_clk_i, irq_enable_i} = 4'h0;
        {pinctl_wr_i, pin_en_wr_i, wdog_wr_i, wdog_service_i} = 4'h0;
        {pinctl_mux_i, pinctl_icfg_i} = '0;
        {pin_en_i, pin_level_i, wdog_wdata_i} = '0;
        boot(4'h0);
        n = 0;
        span(30);
        chk("wdog_fire", 32'h0000_0001, 32'(n > 0));
        wdog_service_i = 1'b1;
        cyc(1);
        n = 0;
        repeat (6)
        begin
            wdog_service_i = 1'b1;
            span(1);
            wdog_service_i = 1'b0;
            span(5);
        end
        chk("wdog_kept", 32'h0000_0000, n);
        wdog_wr_i = 1'b1;
        cyc(1);
        wdog_wr_i = 1'b0;
        chk("wdog_ctl", RBS_WDOG_OFF, wdog_ctrl_o);
        n = 0;
        span(60);
        chk("wdog_off", 32'h0000_0000, {n[30:0], wdog_active_o});
        $display("test watchdog done");
        pinctl(RBS_MUX_GPIO, RBS_ICFG_RISE);
        chk("dig_gate", RBS_SWD_MASK, pin_dig_en_o);
        {port_clk_en_i, periph_clk_i, irq_enable_i} = 3'h7;
        cyc(2);
        chk("sw_on", 32'h0000_0007, {irq_en_o, periph_clk_o, port_clk_o});
        pinctl(RBS_MUX_GPIO, RBS_ICFG_OFF);
        edge_cnt(0);
        pinctl(RBS_MUX_GPIO, RBS_ICFG_RISE);
        edge_cnt(1);
        chk("dig_btn", 32'h0000_0013, pin_dig_en_o);
        {pin_en_i, pin_en_wr_i} = {8'h80, 1'b1};
        cyc(1);
        pin_en_wr_i = 1'b0;
        cyc(2);
        chk("ana_rel", 32'h0000_0040, pin_analog_o);
        vtab_ram_i = 1'b1;
        cyc(2);
        chk("vtab_ram", RBS_SRAM_BASE, vtab_base_o);
        $display("test pins done");
        boot(4'h5);
        close_out();
    end
endmodule // tb_rbs_boot_ctrl
bind rbs_boot_ctrl rbs_boot_props rbs_boot_props_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .vec_req_o(vec_req_o),
    .vec_addr_o(vec_addr_o), .vec_ack_i(vec_ack_i),
    .vec_rdata_i(vec_rdata_i), .core_run_o(core_run_o),
    .core_sp_o(core_sp_o), .core_pc_o(core_pc_o), .clk_mode_o(clk_mode_o),
    .pin_level_i(pin_level_i), .pin_dig_en_o(pin_dig_en_o),
    .pin_irq_o(pin_irq_o), .wdog_wr_i(wdog_wr_i),
    .wdog_wdata_i(wdog_wdata_i), .wdog_ctrl_o(wdog_ctrl_o),
    .wdog_active_o(wdog_active_o));
`default_nettype wire
